//--- design/sea_defs.svh
// Constants for the serial EEPROM array access link and its controller.
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH

// Command opcodes; bit 3 of a received opcode is a don't-care.
`define SEA_OP_MASK 8'hf7
`define SEA_OP_READ 8'h03
`define SEA_OP_WRITE 8'h02
`define SEA_OP_SET_WEL 8'h06
`define SEA_OP_CLR_WEL 8'h04
`define SEA_OP_STATUS 8'h05

// Array geometry.
`define SEA_MEM_BYTES 8192
`define SEA_PAGE_BYTES 32

// Status byte layout and value shown during programming.
`define SEA_STAT_BUSY_BIT 0
`define SEA_STAT_WEL_BIT 1
`define SEA_STAT_BP_LO_BIT 2
`define SEA_STAT_BP_HI_BIT 3
`define SEA_STAT_BUSY_FILL 8'hff

// Lowest protected address for protect levels 1 and 2.
`define SEA_PROT_QUARTER 13'h1800
`define SEA_PROT_HALF 13'h1000

// Timing: system clock period and longest programming time.
`define SEA_CLK_NS 20
`define SEA_TWC_NS 5000000
`define SEA_PROG_CYCLES (`SEA_TWC_NS / `SEA_CLK_NS)
`define SEA_SCK_HALF 3'h3

// Controller register offsets (byte address bits 3:0) and status fields.
`define SEA_REG_CMD 4'h0
`define SEA_REG_DATA 4'h4
`define SEA_REG_END 4'h8
`define SEA_REG_STATUS 4'hc
`define SEA_CST_BUSY_BIT 0
`define SEA_CST_SEL_BIT 1

`endif

//--- design/sea_device.sv
// EEPROM device end: serial command decode, 8 KiB array, page write, programming.
`timescale 1ns/100ps
`include "sea_defs.svh"

// Behaviour
// - Read: opcode, 16-bit address, then data out
// - Address steps after each read byte
// - Read wraps from top to address zero
// - Master ends single read by raising select
// - Write needs latch set by earlier command
// - Protected locations are never programmed
// - Busy: only status read is accepted
// - Write: opcode, address, data bytes, MSB first
// - Programming starts on select rising after write
// - Select must rise right after a data byte
// - Page write steps only low five bits
// - Over 32 bytes wrap, later bytes replace
// - Programming end clears the write latch
// - Write without latch is dropped after the opcode
// - Status bit 0 shows programming in progress
// - Address bits 15 to 13 are ignored
// - Opcodes are eight bits, bit 3 ignored
// - Transfers start at select fall, MSB first
// - Status bit 1 shows the write latch
// - Two protect bits pick the protected range
module sea_device #(
  parameter int unsigned PROG_CYCLES = `SEA_PROG_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial link
  sea_if.dev link,
  // Protect level
  input wire logic protect_level_lo,
  input wire logic protect_level_hi,
  // Observation
  output logic busy,
  output logic write_latch
);
  import sea_pkg::*;

  sea_dev_state_t state;
  logic sck_q;
  logic sel_q;
  logic [2:0] in_cnt;
  logic [7:0] in_sr;
  logic is_write;
  logic addr_second;
  logic [4:0] addr_hi;
  logic [12:0] addr;
  logic [7:0] out_byte;
  logic [2:0] out_cnt;
  logic [31:0] page_valid;
  logic [31:0] timer;
  logic [7:0] mem [0:`SEA_MEM_BYTES-1];
  logic [7:0] page_buf [0:`SEA_PAGE_BYTES-1];
  logic [7:0] status;
  logic [7:0] op;
  logic [12:0] next_addr;
  logic [12:0] commit_addr;

  wire rise = link.sck && !sck_q;
  wire fall = !link.sck && sck_q;
  wire sel_fall = !link.sel_n && sel_q;
  wire sel_rise = link.sel_n && !sel_q;
  wire [7:0] rx_byte = {in_sr[6:0], link.sdi};
  wire byte_done = rise && !link.sel_n && in_cnt == 3'h7;
  wire reading = state == SEA_RDATA || state == SEA_STATUS;
  wire addr_done = byte_done && state == SEA_ADDR && addr_second;
  wire prog_start = sel_rise && state == SEA_WDATA && in_cnt == 3'h0 && page_valid != 32'h0;
  wire prog_end = busy && timer == PROG_CYCLES - 1;
  wire [1:0] prot_lvl = {protect_level_hi, protect_level_lo};

  //////////////////////////////////////////////////////////////////////////
  // Pin history for edge detection; the link is synchronous to hclk.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
    end
    else
    begin
      sck_q <= link.sck;
      sel_q <= link.sel_n;
    end
  end

  // Input bits are taken on rising clock edges, MSB first.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      in_cnt <= 3'h0;
      in_sr <= 8'h00;
    end
    else if (link.sel_n)
      in_cnt <= 3'h0;
    else if (rise)
    begin
      in_sr <= rx_byte;
      in_cnt <= in_cnt + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status byte; while programming every bit reads one.
  always_comb
  begin
    status = 8'h00;
    status[`SEA_STAT_WEL_BIT] = write_latch;
    status[`SEA_STAT_BP_LO_BIT] = protect_level_lo;
    status[`SEA_STAT_BP_HI_BIT] = protect_level_hi;
    if (busy)
      status = `SEA_STAT_BUSY_FILL;
    op = rx_byte & `SEA_OP_MASK;
    next_addr = {addr_hi, rx_byte};
  end

  // Transaction phases. Any select fall restarts decode, so a dropped command
  // leaves the device idle until the next fall.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= SEA_IDLE;
      is_write <= 1'b0;
      addr_second <= 1'b0;
      addr_hi <= 5'h00;
    end
    else if (sel_fall)
    begin
      state <= SEA_CMD;
      addr_second <= 1'b0;
    end
    else if (link.sel_n)
      state <= SEA_IDLE;
    else if (byte_done)
      unique case (state)
        SEA_CMD:
        begin
          is_write <= op == `SEA_OP_WRITE;
          if (op == `SEA_OP_STATUS)
            state <= SEA_STATUS;
          else if (busy)
            state <= SEA_IGNORE;
          else if (op == `SEA_OP_READ)
            state <= SEA_ADDR;
          else if (op == `SEA_OP_WRITE && write_latch)
            state <= SEA_ADDR;
          else
            state <= SEA_IGNORE;
        end
        SEA_ADDR:
        begin
          addr_second <= 1'b1;
          if (!addr_second)
            addr_hi <= rx_byte[4:0];
          else
            state <= is_write ? SEA_WDATA : SEA_RDATA;
        end
        SEA_IDLE, SEA_RDATA, SEA_WDATA, SEA_STATUS, SEA_IGNORE:
        begin
        end
      endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte address: loaded after the address, page-local step on writes, full
  // 13-bit step with natural wrap on reads.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      addr <= 13'h0000;
    else if (addr_done)
      addr <= next_addr;
    else if (byte_done && state == SEA_WDATA)
      addr[4:0] <= addr[4:0] + 5'h01;
    else if (fall && state == SEA_RDATA && out_cnt == 3'h7)
      addr <= addr + 13'h0001;
  end

  // Page buffer; a repeated location keeps the latest byte.
  always_ff @(posedge hclk)
  begin
    if (byte_done && state == SEA_WDATA)
      page_buf[addr[4:0]] <= rx_byte;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      page_valid <= 32'h0;
    else if (addr_done && is_write)
      page_valid <= 32'h0;
    else if (byte_done && state == SEA_WDATA)
      page_valid[addr[4:0]] <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Output shifter: new bit after each falling clock; the first bit goes out
  // on the fall after the last address or opcode bit.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_byte <= 8'h00;
      out_cnt <= 3'h0;
      link.sdo <= 1'b0;
    end
    else if (addr_done && !is_write)
    begin
      out_byte <= mem[next_addr];
      out_cnt <= 3'h0;
    end
    else if (byte_done && state == SEA_CMD)
    begin
      out_byte <= status;
      out_cnt <= 3'h0;
    end
    else if (fall && reading && !link.sel_n)
    begin
      link.sdo <= out_byte[3'h7 - out_cnt];
      out_cnt <= out_cnt + 3'h1;
      if (out_cnt == 3'h7)
        out_byte <= state == SEA_RDATA ? mem[addr + 13'h0001] : status;
    end
  end

  // Output pin is driven only while selected in a read phase.
  assign link.sdo_oe = !link.sel_n && reading;

  //////////////////////////////////////////////////////////////////////////
  // Programming timer. Requires PROG_CYCLES above the page size, as the
  // commit below walks one page entry per cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy <= 1'b0;
      timer <= 32'h0;
    end
    else if (prog_start && !busy)
    begin
      busy <= 1'b1;
      timer <= 32'h0;
    end
    else if (prog_end)
      busy <= 1'b0;
    else if (busy)
      timer <= timer + 32'h1;
  end

  // Write latch: set and cleared by commands, cleared when programming ends.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      write_latch <= 1'b0;
    else if (prog_end)
      write_latch <= 1'b0;
    else if (byte_done && state == SEA_CMD && !busy && op == `SEA_OP_SET_WEL)
      write_latch <= 1'b1;
    else if (byte_done && state == SEA_CMD && !busy && op == `SEA_OP_CLR_WEL)
      write_latch <= 1'b0;
  end

  // Array commit, one page entry per cycle at the start of programming.
  assign commit_addr = {addr[12:5], timer[4:0]};

  always_ff @(posedge hclk)
  begin
    if (busy && timer < `SEA_PAGE_BYTES && page_valid[timer[4:0]]
        && !sea_protected(commit_addr, prot_lvl))
      mem[commit_addr] <= page_buf[timer[4:0]];
  end

endmodule : sea_device

//--- design/sea_host.sv
// Bus master controller end: AHB-Lite registers drive byte transfers on the link.
`timescale 1ns/100ps
`include "sea_defs.svh"

module sea_host
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial link
  sea_if.host link
);
  import sea_pkg::*;

  logic wr_pend;
  logic [3:0] wr_off;
  logic sel_active;
  logic start;
  logic [7:0] tx_byte;
  logic busy;
  logic [7:0] rx_byte;
  wire take = hsel && hready && htrans[1];

  //////////////////////////////////////////////////////////////////////////
  // Zero-wait slave; every access completes with OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; read data is registered for the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_off <= 4'h0;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend <= take && hwrite;
      wr_off <= haddr[3:0];
      if (take && !hwrite)
        case (haddr[3:0])
          `SEA_REG_DATA: hrdata <= {24'h0, rx_byte};
          `SEA_REG_STATUS: hrdata <= {16'h0, rx_byte, 6'h0, sel_active, busy};
          default: hrdata <= 32'h0;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // A command write lowers select and sends the opcode; a data write sends a
  // byte; writes while a byte is moving are dropped, so software polls busy.
  always_comb
  begin
    start = 1'b0;
    tx_byte = hwdata[7:0];
    if (wr_pend && !busy && wr_off == `SEA_REG_CMD)
    begin
      start = 1'b1;
      tx_byte = sea_opcode(hwdata[2:0]);
    end
    else if (wr_pend && !busy && wr_off == `SEA_REG_DATA && sel_active)
      start = 1'b1;
  end

  // Select: falls with each command, rises only between bytes with the clock
  // low, which is what lets a write be programmed.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_active <= 1'b0;
    else if (wr_pend && !busy && wr_off == `SEA_REG_CMD)
      sel_active <= 1'b1;
    else if (wr_pend && !busy && wr_off == `SEA_REG_END)
      sel_active <= 1'b0;
  end

  assign link.sel_n = !sel_active;

  sea_shifter u_shifter
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start),
    .tx_byte(tx_byte),
    .busy(busy),
    .rx_byte(rx_byte),
    .sck(link.sck),
    .sdo_out(link.sdi),
    .sdi_in(link.sdo_line)
  );

endmodule : sea_host

//--- design/sea_if.sv
// Serial link between the EEPROM device and its bus master controller.
`timescale 1ns/100ps

interface sea_if;
  logic sck;
  logic sel_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // The output pin floats while undriven; a pull-up makes it read high.
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (input sck, input sel_n, input sdi, output sdo, output sdo_oe);
  modport host (output sck, output sel_n, output sdi, input sdo_line);
endinterface : sea_if

//--- design/sea_pkg.sv
// Types and helper functions shared by both ends of the EEPROM link.
`include "sea_defs.svh"

package sea_pkg;

  // Device-side transaction phase.
  typedef enum logic [2:0] {
    SEA_IDLE,
    SEA_CMD,
    SEA_ADDR,
    SEA_RDATA,
    SEA_WDATA,
    SEA_STATUS,
    SEA_IGNORE
  } sea_dev_state_t;

  // True when an address sits inside the range guarded by the protect level.
  function automatic logic sea_protected(logic [12:0] a, logic [1:0] lvl);
    logic r;
    r = 1'b0;
    unique case (lvl)
      2'h0: r = 1'b0;
      2'h1: r = (a >= `SEA_PROT_QUARTER);
      2'h2: r = (a >= `SEA_PROT_HALF);
      2'h3: r = 1'b1;
    endcase
    return r;
  endfunction : sea_protected

  // Opcode for a controller command kind.
  function automatic logic [7:0] sea_opcode(logic [2:0] kind);
    logic [7:0] op;
    op = `SEA_OP_STATUS;
    case (kind)
      3'h0: op = `SEA_OP_READ;
      3'h1: op = `SEA_OP_WRITE;
      3'h2: op = `SEA_OP_SET_WEL;
      3'h4: op = `SEA_OP_CLR_WEL;
      default: op = `SEA_OP_STATUS;
    endcase
    return op;
  endfunction : sea_opcode

endpackage : sea_pkg

//--- design/sea_shifter.sv
// Mode 0 byte shifter: makes the serial clock and moves one byte each way.
`timescale 1ns/100ps
`include "sea_defs.svh"

module sea_shifter
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Byte request
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output logic [7:0] rx_byte,
  // Serial pins
  output logic sck,
  output logic sdo_out,
  input wire logic sdi_in
);
  import sea_pkg::*;

  logic [2:0] div;
  logic [2:0] bit_cnt;
  logic [7:0] tx_sr;
  wire tick = busy && (div == `SEA_SCK_HALF - 3'h1);

  //////////////////////////////////////////////////////////////////////////
  // Half-period divider; restarts with each byte so the first edge is clean.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div <= 3'h0;
    else if (start || tick)
      div <= 3'h0;
    else if (busy)
      div <= div + 3'h1;
  end

  // Clock low on idle; data bit set up a half period before each rise, and
  // the byte always ends with the clock low so select may rise straight after.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy <= 1'b0;
      sck <= 1'b0;
      sdo_out <= 1'b0;
      bit_cnt <= 3'h0;
      tx_sr <= 8'h00;
      rx_byte <= 8'h00;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      sdo_out <= tx_byte[7];
      tx_sr <= {tx_byte[6:0], 1'b0};
      bit_cnt <= 3'h0;
    end
    else if (tick && !sck)
    begin
      sck <= 1'b1;
      rx_byte <= {rx_byte[6:0], sdi_in};
    end
    else if (tick)
    begin
      sck <= 1'b0;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
        busy <= 1'b0;
      else
      begin
        sdo_out <= tx_sr[7];
        tx_sr <= {tx_sr[6:0], 1'b0};
      end
    end
  end

endmodule : sea_shifter

//--- sim/sea_chk.sv
// Assertion checker for the serial link pins and the device programming flags.
`timescale 1ns/100ps

module sea_chk #(
  parameter int unsigned PROG_CYCLES = 64
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link pins and device flags
  input wire logic sck,
  input wire logic sel_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic busy,
  input wire logic write_latch
);
  int unsigned busy_run;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////
  // Length of the current programming run; a short or stuck timer shows here.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_run <= 0;
    else
      busy_run <= busy ? busy_run + 1 : 0;
  end
  //////////////////////////////////////////////////////////////////////
  // Pin framing: output released and clock parked outside a frame.
  oe_released_a: assert property (sel_n |-> !sdo_oe)
    else $error("output driven while deselected");
  sck_parked_a: assert property (sel_n |-> !sck)
    else $error("serial clock moving outside a frame");
  sel_edge_a: assert property ($changed(sel_n) |-> !sck && !$past(sck))
    else $error("select moved while serial clock high");
  sdo_edge_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck)
    else $error("serial output changed while clock high");
  // Programming cycle: start, length and latch handling.
  prog_start_a: assert property ($rose(busy) |-> sel_n && write_latch)
    else $error("programming began without latch or inside a frame");
  prog_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("programming cycle cut short");
  prog_len_a: assert property ($fell(busy) |->
    busy_run >= PROG_CYCLES - 1 && busy_run <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  prog_cap_a: assert property (busy |-> busy_run < PROG_CYCLES + 2)
    else $error("programming overran its timer");
  latch_clear_a: assert property ($fell(busy) |-> !write_latch)
    else $error("write latch still set after programming");
  latch_frozen_a: assert property (busy && $past(busy) |-> $stable(write_latch))
    else $error("write latch changed while programming");
endmodule : sea_chk

//--- sim/tb_top.sv
// Self-checking bench: host controller and EEPROM device joined over the link.
`timescale 1ns/100ps

module tb_top;
  import sea_pkg::*;
  // Short programming time keeps the run brief; it must stay above one page.
  localparam int unsigned PROG = 1000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [1:0] lvl = 2'h0;
  logic busy;
  logic write_latch;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] mem [int];
  logic [12:0] tbl [4] = '{13'h0fff, 13'h1000, 13'h17ff, 13'h1800};
  sea_if link ();
  sea_host u_sea_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link.host));
  sea_device #(.PROG_CYCLES(PROG)) u_sea_device (.hclk(hclk), .hresetn(hresetn),
    .link(link.dev), .protect_level_lo(lvl[0]), .protect_level_hi(lvl[1]), .busy(busy),
    .write_latch(write_latch));
  sea_chk #(.PROG_CYCLES(PROG)) u_sea_chk (.hclk(hclk), .hresetn(hresetn), .sck(link.sck),
    .sel_n(link.sel_n), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .busy(busy),
    .write_latch(write_latch));
  always #10 hclk = ~hclk;
  //////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_up(input string what);
    bad_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    results();
  endtask : give_up
  //////////////////////////////////////////////////////////////////////
  // Bus side: one single-word transfer, address phase held until hready is high.
  task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("bus response", 8'h00, {7'h0, hresp});
  endtask : ahb
  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      give_up("hready");
  endtask : rdy
  // Busy is set on the edge that ends the data phase; polling still waits two edges first.
  task automatic idle();
    logic [31:0] q;
    repeat (2) @(posedge hclk);
    for (int n = 0; n < 100; n++)
    begin
      ahb(1'b0, 4'hc, 32'h0, q);
      if (q[0] === 1'b0)
        return;
    end
    give_up("byte shift");
  endtask : idle
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [31:0] q;
    ahb(1'b1, 4'h4, {24'h0, tx}, q);
    idle();
    ahb(1'b0, 4'h4, 32'h0, q);
    rx = q[7:0];
  endtask : xfer
  task automatic go(input logic [2:0] kind, input logic [15:0] a, input logic adr);
    logic [31:0] q;
    logic [7:0] rx;
    ahb(1'b1, 4'h0, {29'h0, kind}, q);
    idle();
    if (adr)
    begin
      xfer(a[15:8], rx);
      xfer(a[7:0], rx);
    end
  endtask : go
  task automatic stop();
    logic [31:0] q;
    ahb(1'b1, 4'h8, 32'h0, q);
    repeat (2) @(posedge hclk);
  endtask : stop
  task automatic status(output logic [7:0] st);
    go(3'h3, 16'h0, 1'b0);
    xfer(8'h00, st);
    stop();
  endtask : status
  //////////////////////////////////////////////////////////////////////
  // Expected model: protected range from the level pins, page-wrapped writes.
  function automatic logic prot(input logic [12:0] a);
    return lvl == 2'h3 || (lvl == 2'h2 && a >= 13'h1000) || (lvl == 2'h1 && a >= 13'h1800);
  endfunction : prot
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0, input logic en);
    logic [7:0] rx;
    logic [7:0] st;
    logic ok;
    ok = en && !prot(a[12:0]);
    st = 8'h01;
    if (en)
    begin
      go(3'h2, 16'h0, 1'b0);
      stop();
    end
    go(3'h1, a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      xfer(d0 + 8'(i), rx);
      if (ok)
        mem[{a[12:5], 5'(a[4:0] + i)}] = d0 + 8'(i);
    end
    stop();
    if (ok || !en)
      chk("programming busy", {7'h0, ok}, {7'h0, busy});
    if (ok)
    begin
      status(st);
      chk("status while busy", 8'hff, st);
      go(3'h0, a, 1'b1);
      xfer(8'h00, rx);
      stop();
      chk("read while busy", 8'hff, rx);
      go(3'h2, 16'h0, 1'b0);
      stop();
    end
    for (int i = 0; i < 60 && st[0] !== 1'b0; i++)
      status(st);
    if (st[0] !== 1'b0)
      give_up("programming");
    if (ok)
      chk("latch after programming", 8'h00, {7'h0, write_latch});
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n);
    logic [7:0] rx;
    int k;
    go(3'h0, a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      xfer(8'h00, rx);
      k = (a[12:0] + i) % 8192;
      if (mem.exists(k))
        chk("read byte", mem[k], rx);
    end
    stop();
  endtask : rd
  //////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_status();
    logic [7:0] st;
    chk("select idle", 8'h01, {7'h0, link.sel_n});
    status(st);
    chk("status at reset", 8'h00, st);
    go(3'h2, 16'h0, 1'b0);
    stop();
    status(st);
    chk("status latch set", 8'h02, st);
    go(3'h4, 16'h0, 1'b0);
    stop();
    status(st);
    chk("status latch clear", 8'h00, st);
    $display("test status done");
  endtask : t_status
  task automatic t_page();
    wr(16'hf01e, 34, 8'h40, 1'b1);
    rd(16'h1000, 32);
    wr(16'h101e, 1, 8'h99, 1'b0);
    rd(16'h101e, 1);
    $display("test page done");
  endtask : t_page
  task automatic t_prot();
    logic [7:0] st;
    for (int l = 0; l < 4; l++)
    begin
      lvl <= 2'(l);
      @(posedge hclk);
      status(st);
      chk("protect bits", {4'h0, 2'(l), 2'h0}, st);
      for (int j = 0; j < 4; j++)
        wr({3'h0, tbl[j]}, 1, 8'(16 * l + j), 1'b1);
    end
    for (int j = 0; j < 4; j++)
      rd({3'h0, tbl[j]}, 1);
    lvl <= 2'h0;
    @(posedge hclk);
    $display("test protect done");
  endtask : t_prot
  task automatic t_wrap();
    wr(16'h1fff, 1, 8'ha7, 1'b1);
    wr(16'h0000, 1, 8'h3c, 1'b1);
    rd(16'h1fff, 2);
    $display("test wrap done");
  endtask : t_wrap
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_status();
    t_page();
    t_prot();
    t_wrap();
    results();
  end
endmodule : tb_top
